/* File: core/gauge_flag_params.svh */
// Offsets, bit positions, error codes and counts for the gauge flag word.
`ifndef GAUGE_FLAG_PARAMS_SVH
`define GAUGE_FLAG_PARAMS_SVH

`define FLAG_WORD_CMD 8'h16
`define FLAG_WORD_RESET 16'h0040
`define ERR_FIELD_LSB 0
`define ERR_FIELD_MSB 3
`define BIT_FULLY_DISCHARGED 4
`define BIT_FULLY_CHARGED 5
`define BIT_DISCHARGING 6
`define BIT_INITIALIZED 7
`define BIT_TIME_ALARM 8
`define BIT_CAPACITY_ALARM 9
`define BIT_TERM_DISCHARGE_ALARM 11
`define BIT_OVER_TEMP_ALARM 12
`define BIT_TERM_CHARGE_ALARM 14
`define BIT_OVER_CHARGED_ALARM 15
`define ERR_OK 4'h0
`define ERR_BUSY 4'h1
`define ERR_RESERVED 4'h2
`define ERR_UNSUPPORTED 4'h3
`define ERR_ACCESS_DENIED 4'h4
`define ERR_OVERFLOW 4'h5
`define ERR_BAD_SIZE 4'h6
`define ERR_UNKNOWN 4'h7
`define ERR_ALL_ONES 4'hf
`define FD_CLEAR_PERCENT 16'h0014
`define SECONDS_PER_MINUTE 32'h0000003c
`define OVERCHG_CLEAR_MAH 2
`define CHARGE_TICKS_PER_MAH 10

`endif

/* File: core/gauge_flag_pkg.sv */
// Types shared by the gauge flag word design.
package gauge_flag_pkg;
  `include "gauge_flag_params.svh"

  typedef enum logic [3:0] {
    ERRC_OK = `ERR_OK,
    ERRC_BUSY = `ERR_BUSY,
    ERRC_RESERVED = `ERR_RESERVED,
    ERRC_UNSUPPORTED = `ERR_UNSUPPORTED,
    ERRC_ACCESS_DENIED = `ERR_ACCESS_DENIED,
    ERRC_OVERFLOW = `ERR_OVERFLOW,
    ERRC_BAD_SIZE = `ERR_BAD_SIZE,
    ERRC_UNKNOWN = `ERR_UNKNOWN
  } err_code_t;
endpackage : gauge_flag_pkg

/* File: core/error_code_select.sv */
// Picks and holds the error code that reports the last command outcome.
`timescale 1ns/1ps
`include "gauge_flag_params.svh"
module error_code_select
  import gauge_flag_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Command outcome.
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic core_busy,
  input wire logic cmd_reserved,
  input wire logic cmd_unsupported,
  input wire logic cmd_read_only,
  input wire logic cmd_bad_size,
  input wire logic cmd_overflow,
  input wire logic cmd_unknown,
  // Held code.
  output err_code_t err_code_reg
);
  err_code_t err_code_next;

  always_comb begin
    err_code_next = ERRC_OK;
    // R18 busy first
    if (core_busy) begin
      err_code_next = ERRC_BUSY;
    // R19 reserved codes
    end else if (cmd_reserved) begin
      err_code_next = ERRC_RESERVED;
    // R20 unimplemented commands
    end else if (cmd_unsupported) begin
      err_code_next = ERRC_UNSUPPORTED;
    // R21 read-only writes
    end else if (cmd_write && (cmd_read_only || cmd_code == `FLAG_WORD_CMD)) begin
      err_code_next = ERRC_ACCESS_DENIED;
    // R22 size and overflow
    end else if (cmd_write && cmd_bad_size) begin
      err_code_next = ERRC_BAD_SIZE;
    end else if (cmd_overflow) begin
      err_code_next = ERRC_OVERFLOW;
    end else if (cmd_unknown) begin
      err_code_next = ERRC_UNKNOWN;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      err_code_reg <= ERRC_OK;
    end else if (cmd_valid) begin
      err_code_reg <= err_code_next;
    end
  end
endmodule : error_code_select

/* File: core/discharge_accumulator.sv */
// Counts continuous non-charging charge ticks up to the overcharge clear amount.
`timescale 1ns/1ps
`include "gauge_flag_params.svh"
module discharge_accumulator
  import gauge_flag_pkg::*;
#(
  parameter int TICKS = `OVERCHG_CLEAR_MAH * `CHARGE_TICKS_PER_MAH
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Activity.
  input wire logic charging,
  input wire logic charge_tick,
  // Result.
  output logic done_reg
);
  localparam int CW = $clog2(TICKS + 1);
  logic [CW-1:0] count_reg;

  if (TICKS < 1) begin : g_chk
    $error("discharge_accumulator needs TICKS of at least one");
  end

  // R5 continuous 2 mAh
  always_ff @(posedge core_clk) begin
    if (!reset_n || charging) begin
      count_reg <= '0;
    end else if (charge_tick && count_reg != CW'(TICKS)) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n || charging) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (count_reg == CW'(TICKS));
    end
  end
endmodule : discharge_accumulator

/* File: core/gauge_flag_word.sv */
// Gauge flag word: alarm and status flags, error code, read-word and alarm broadcast.
//
// Contract
// R1 - Host reads word with read-word command 16h.
// R2 - Broadcast copy forces all error bits high.
// R3 - Time alarm uses current or power per mode.
// R4 - Set overcharge beyond full plus maximum overcharge.
// R5 - Clear overcharge after stop and 2 mAh.
// R6 - Charge-termination alarm: set on termination, clear uncharged.
// R7 - Over-temperature set at charge/discharge threshold.
// R8 - Over-temperature clears below matching reset threshold.
// R9 - Discharge-termination set on any empty condition; code sets on pack voltage equal to, not below, terminate voltage.
// R10 - Discharge-termination clears when all conditions recover.
// R11 - Capacity alarm against host level, cleared properly.
// R12 - Time alarm against host level, cleared properly.
// R13 - Initialized set on valid load, cleared improper.
// R14 - Discharging flag is inverse of charging.
// R15 - Fully charged set at termination, clears percent.
// R16 - Fully discharged set by voltage or percent.
// R17 - Fully discharged clears at 20 percent.
// R18 - Report OK or busy per command.
// R19 - Reserved code for reserved or optional commands.
// R20 - Unsupported code for unimplemented defined commands.
// R21 - Access denied for writes to read-only.
// R22 - Bad size, overflow and unknown codes.
// R23 - Fixed bit layout of flags and code.
// R24 - Reserved bits zero; writes to word ignored.
`timescale 1ns/1ps
`include "gauge_flag_params.svh"
module gauge_flag_word
  import gauge_flag_pkg::*;
#(
  parameter int WORD_W = 16,
  parameter int CLEAR_TICKS = `OVERCHG_CLEAR_MAH * `CHARGE_TICKS_PER_MAH
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Command port from the bus engine.
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic core_busy,
  input wire logic cmd_reserved,
  input wire logic cmd_unsupported,
  input wire logic cmd_read_only,
  input wire logic cmd_bad_size,
  input wire logic cmd_overflow,
  input wire logic cmd_unknown,
  // Read answer.
  output logic rd_valid_reg,
  output logic [WORD_W-1:0] rd_data_reg,
  // Alarm broadcast.
  input wire logic broadcast_req,
  output logic alarm_valid_reg,
  output logic [WORD_W-1:0] alarm_broadcast_reg,
  // Live word.
  output logic [WORD_W-1:0] gauge_flag_word_reg,
  // Gauge state.
  input wire logic charging,
  input wire logic charge_termination,
  input wire logic charge_tick,
  input wire logic capacity_mode,
  input wire logic [WORD_W-1:0] remaining_charge_value,
  input wire logic [WORD_W-1:0] full_charge_value,
  input wire logic [WORD_W-1:0] max_overcharge,
  input wire logic [WORD_W-1:0] temperature,
  input wire logic [WORD_W-1:0] over_temp_charge,
  input wire logic [WORD_W-1:0] over_temp_charge_reset,
  input wire logic [WORD_W-1:0] over_temp_discharge,
  input wire logic [WORD_W-1:0] over_temp_discharge_reset,
  input wire logic [WORD_W-1:0] pack_voltage,
  input wire logic [WORD_W-1:0] cell_voltage,
  input wire logic [WORD_W-1:0] terminate_voltage,
  input wire logic [WORD_W-1:0] suspend_temp_low,
  input wire logic cell_undervoltage_indication,
  input wire logic [WORD_W-1:0] capacity_alarm_level,
  input wire logic [WORD_W-1:0] time_alarm_level,
  input wire logic [WORD_W-1:0] discharge_current,
  input wire logic [WORD_W-1:0] discharge_power,
  input wire logic [WORD_W-1:0] average_time_to_empty_value,
  input wire logic [WORD_W-1:0] relative_charge_percent,
  input wire logic [WORD_W-1:0] full_clear_percent,
  input wire logic [WORD_W-1:0] battery_low_percent,
  input wire logic [WORD_W-1:0] second_end_of_discharge_threshold,
  input wire logic [WORD_W-1:0] overload_current,
  input wire logic config_valid_load,
  input wire logic config_bad_load
);
  if (WORD_W != 16) begin : g_chk
    $error("gauge_flag_word serves a 16-bit word only");
  end

  // Minutes left below the level: remaining*60 < level*rate avoids a divider.
  function automatic logic time_short(input logic [15:0] rem, input logic [15:0] lvl,
                                      input logic [15:0] rate);
    logic [31:0] left;
    logic [31:0] need;
    left = 32'(rem) * `SECONDS_PER_MINUTE;
    need = 32'(lvl) * 32'(rate);
    time_short = (rate != 16'h0000) && (left < need);
  endfunction : time_short

  logic over_charged_reg;
  logic term_charge_reg;
  logic over_temp_reg;
  logic term_discharge_reg;
  logic capacity_alarm_reg;
  logic time_alarm_reg;
  logic initialized_reg;
  logic fully_charged_reg;
  logic fully_discharged_reg;
  logic [15:0] remaining_prev_reg;
  logic [15:0] atte_prev_reg;
  logic overchg_done;
  logic overchg_cond;
  logic [15:0] rate_sel;
  logic [WORD_W-1:0] word_next;
  err_code_t err_code;

  error_code_select u_err (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .cmd_valid(cmd_valid),
    .cmd_write(cmd_write),
    .cmd_code(cmd_code),
    .core_busy(core_busy),
    .cmd_reserved(cmd_reserved),
    .cmd_unsupported(cmd_unsupported),
    .cmd_read_only(cmd_read_only),
    .cmd_bad_size(cmd_bad_size),
    .cmd_overflow(cmd_overflow),
    .cmd_unknown(cmd_unknown),
    .err_code_reg(err_code)
  );

  discharge_accumulator #(.TICKS(CLEAR_TICKS)) u_acc (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .charging(charging),
    .charge_tick(charge_tick),
    .done_reg(overchg_done)
  );

  // R4 overcharge limit
  assign overchg_cond = charging &&
    ({1'b0, remaining_charge_value} > ({1'b0, full_charge_value} + {1'b0, max_overcharge}));
  // R3 rate by mode
  assign rate_sel = capacity_mode ? discharge_power : discharge_current;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      remaining_prev_reg <= 16'h0000;
      atte_prev_reg <= 16'h0000;
    end else begin
      remaining_prev_reg <= remaining_charge_value;
      atte_prev_reg <= average_time_to_empty_value;
    end
  end

  // R4 R5 overcharge alarm
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      over_charged_reg <= 1'b0;
    end else if (overchg_cond) begin
      over_charged_reg <= 1'b1;
    end else if (!charging && overchg_done) begin
      over_charged_reg <= 1'b0;
    end
  end

  // R6 termination alarm
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      term_charge_reg <= 1'b0;
    end else if (charge_termination) begin
      term_charge_reg <= 1'b1;
    end else if (!charging) begin
      term_charge_reg <= 1'b0;
    end
  end

  // R7 R8 temperature alarm
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      over_temp_reg <= 1'b0;
    end else if (charging ? (temperature >= over_temp_charge)
                          : (temperature >= over_temp_discharge)) begin
      over_temp_reg <= 1'b1;
    end else if (charging ? (temperature < over_temp_charge_reset)
                          : (temperature < over_temp_discharge_reset)) begin
      over_temp_reg <= 1'b0;
    end
  end

  // R9 R10 discharge termination
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      term_discharge_reg <= 1'b0;
    end else if (remaining_charge_value == 16'h0000 || pack_voltage == terminate_voltage ||
                 temperature <= suspend_temp_low || cell_undervoltage_indication) begin
      term_discharge_reg <= 1'b1;
    end else if (pack_voltage > terminate_voltage && remaining_charge_value != 16'h0000 &&
                 !cell_undervoltage_indication) begin
      term_discharge_reg <= 1'b0;
    end
  end

  // R11 capacity alarm
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      capacity_alarm_reg <= 1'b0;
    end else if (!charging && remaining_charge_value < capacity_alarm_level) begin
      capacity_alarm_reg <= 1'b1;
    end else if (capacity_alarm_level < remaining_charge_value ||
                 (charging && remaining_charge_value > remaining_prev_reg)) begin
      capacity_alarm_reg <= 1'b0;
    end
  end

  // R12 R3 time alarm
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      time_alarm_reg <= 1'b0;
    end else if (!charging && time_short(remaining_charge_value, time_alarm_level,
                                         rate_sel)) begin
      time_alarm_reg <= 1'b1;
    end else if (time_alarm_level < average_time_to_empty_value ||
                 (charging && average_time_to_empty_value > atte_prev_reg)) begin
      time_alarm_reg <= 1'b0;
    end
  end

  // R13 configuration load
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      initialized_reg <= 1'b0;
    end else if (config_valid_load) begin
      initialized_reg <= 1'b1;
    end else if (config_bad_load) begin
      initialized_reg <= 1'b0;
    end
  end

  // R15 fully charged
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      fully_charged_reg <= 1'b0;
    end else if (charge_termination || overchg_cond) begin
      fully_charged_reg <= 1'b1;
    end else if (relative_charge_percent < full_clear_percent) begin
      fully_charged_reg <= 1'b0;
    end
  end

  // R16 R17 fully discharged
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      fully_discharged_reg <= 1'b0;
    end else if (((pack_voltage < second_end_of_discharge_threshold ||
                   cell_voltage < second_end_of_discharge_threshold) &&
                  discharge_current < overload_current) ||
                 relative_charge_percent < battery_low_percent) begin
      fully_discharged_reg <= 1'b1;
    end else if (relative_charge_percent >= `FD_CLEAR_PERCENT) begin
      fully_discharged_reg <= 1'b0;
    end
  end

  // R23 R24 word layout
  always_comb begin
    word_next = '0;
    word_next[`ERR_FIELD_MSB:`ERR_FIELD_LSB] = err_code;
    word_next[`BIT_FULLY_DISCHARGED] = fully_discharged_reg;
    word_next[`BIT_FULLY_CHARGED] = fully_charged_reg;
    // R14 discharging flag
    word_next[`BIT_DISCHARGING] = !charging;
    word_next[`BIT_INITIALIZED] = initialized_reg;
    word_next[`BIT_TIME_ALARM] = time_alarm_reg;
    word_next[`BIT_CAPACITY_ALARM] = capacity_alarm_reg;
    word_next[`BIT_TERM_DISCHARGE_ALARM] = term_discharge_reg;
    word_next[`BIT_OVER_TEMP_ALARM] = over_temp_reg;
    word_next[`BIT_TERM_CHARGE_ALARM] = term_charge_reg;
    word_next[`BIT_OVER_CHARGED_ALARM] = over_charged_reg;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      gauge_flag_word_reg <= `FLAG_WORD_RESET;
    end else begin
      gauge_flag_word_reg <= word_next;
    end
  end

  // R1 read-word answer
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rd_valid_reg <= 1'b0;
      rd_data_reg <= '0;
    end else begin
      rd_valid_reg <= cmd_valid && !cmd_write && cmd_code == `FLAG_WORD_CMD;
      if (cmd_valid && !cmd_write && cmd_code == `FLAG_WORD_CMD) begin
        rd_data_reg <= gauge_flag_word_reg;
      end
    end
  end

  // R2 broadcast copy
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      alarm_valid_reg <= 1'b0;
      alarm_broadcast_reg <= '0;
    end else begin
      alarm_valid_reg <= broadcast_req;
      if (broadcast_req) begin
        alarm_broadcast_reg <= {gauge_flag_word_reg[WORD_W-1:`ERR_FIELD_MSB+1], `ERR_ALL_ONES};
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  read_answer_a: assert property ( // R1
    cmd_valid && !cmd_write && cmd_code == `FLAG_WORD_CMD |=>
      rd_valid_reg && rd_data_reg == $past(gauge_flag_word_reg))
    else $error("flag word read not answered");
  broadcast_ones_a: assert property ( // R2
    broadcast_req |=> alarm_valid_reg && alarm_broadcast_reg[3:0] == 4'hf &&
      alarm_broadcast_reg[15:4] == $past(gauge_flag_word_reg[15:4]))
    else $error("broadcast error bits not forced high");
  overchg_set_a: assert property ( // R4
    overchg_cond |=> ##1 gauge_flag_word_reg[15] && gauge_flag_word_reg[5])
    else $error("overcharge alarm not set");
  overchg_hold_a: assert property ( // R5
    over_charged_reg && charging |=> over_charged_reg)
    else $error("overcharge alarm cleared while charging");
  term_charge_a: assert property ( // R6
    !charging && !charge_termination |=> !term_charge_reg)
    else $error("charge termination alarm not cleared");
  discharging_bit_a: assert property ( // R14
    charging |=> gauge_flag_word_reg[6] == 1'b0)
    else $error("discharging bit set while charging");
  term_dsg_a: assert property ( // R9
    cell_undervoltage_indication |=> term_discharge_reg)
    else $error("discharge termination not set");
  fd_clear_a: assert property ( // R17
    relative_charge_percent >= 16'h0014 && relative_charge_percent >= battery_low_percent &&
      pack_voltage >= second_end_of_discharge_threshold &&
      cell_voltage >= second_end_of_discharge_threshold |=> !fully_discharged_reg)
    else $error("fully discharged not cleared");
  busy_code_a: assert property ( // R18
    cmd_valid && core_busy |=> err_code == ERRC_BUSY ##1 gauge_flag_word_reg[3:0] == 4'h1)
    else $error("busy code not reported");
  write_denied_a: assert property ( // R21
    cmd_valid && cmd_write && cmd_code == `FLAG_WORD_CMD && !core_busy && !cmd_reserved &&
      !cmd_unsupported |=> err_code == ERRC_ACCESS_DENIED && !rd_valid_reg)
    else $error("write to flag word not denied");
  reserved_zero_a: assert property ( // R24
    gauge_flag_word_reg[10] == 1'b0 && gauge_flag_word_reg[13] == 1'b0)
    else $error("reserved flag bits not zero");

  read_seen_c: cover property (rd_valid_reg);
  broadcast_seen_c: cover property (alarm_valid_reg && gauge_flag_word_reg[12]);
  overchg_cycle_c: cover property (over_charged_reg ##[1:200] !over_charged_reg);
endmodule : gauge_flag_word

/* File: dv/host_cmd_model.sv */
// Host-side command source feeding classified commands to the flag word.
`timescale 1ns/1ps
module host_cmd_model (
  // Clock.
  input wire logic core_clk,
  // Command port.
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic core_busy,
  output logic [5:0] cmd_class
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    core_busy = 1'b0;
    cmd_class = 6'h00;
  end
  task automatic issue(input logic wr, input logic [7:0] code, input logic [6:0] cls);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code = code;
    core_busy = cls[6];
    cmd_class = cls[5:0];
    @(negedge core_clk);
    // Idle write, code and class lines carry the inverse so a stale value never passes for a live one.
    cmd_valid = 1'b0;
    cmd_write = ~wr;
    cmd_code = ~code;
    core_busy = 1'b0;
    cmd_class = ~cls[5:0];
  endtask : issue
endmodule : host_cmd_model

/* File: dv/gauge_flag_word_tb.sv */
// Self-checking bench for the gauge flag word.
`timescale 1ns/1ps
`include "gauge_flag_params.svh"
module gauge_flag_word_tb;
  localparam int TK = 3;
  localparam logic [11:0] ETAB [11] = '{
    {8'h40, `ERR_BUSY}, {8'h60, `ERR_BUSY}, {8'h20, `ERR_RESERVED}, {8'h30, `ERR_RESERVED},
    {8'h10, `ERR_UNSUPPORTED}, {8'h8c, `ERR_ACCESS_DENIED}, {8'h86, `ERR_BAD_SIZE},
    {8'h04, `ERR_OK}, {8'h03, `ERR_OVERFLOW}, {8'h01, `ERR_UNKNOWN}, {8'h00, `ERR_OK}};
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid, cmd_write, core_busy, rd_valid_reg, alarm_valid_reg;
  logic [7:0] cmd_code;
  logic [5:0] cls;
  logic [15:0] rd_data_reg, alarm_broadcast_reg, word;
  logic broadcast_req, charging, charge_termination, charge_tick, capacity_mode;
  logic cuv, cfg_ok, cfg_bad;
  logic [15:0] rem, full, maxo, temp, otc, otcr, otd, otdr, vpk, vcl, vtm, tlo;
  logic [15:0] cap_l, time_l, i_d, p_d, atte, rsoc, fc_c, low_p, edv, i_ov;
  int n_errors = 0;
  int n_checks = 0;
  always #10 core_clk = ~core_clk;
  host_cmd_model host (.core_clk, .cmd_valid, .cmd_write, .cmd_code, .core_busy,
    .cmd_class(cls));
  gauge_flag_word #(.CLEAR_TICKS(TK)) dut (
    .core_clk, .reset_n, .cmd_valid, .cmd_write, .cmd_code, .core_busy,
    .cmd_reserved(cls[5]), .cmd_unsupported(cls[4]), .cmd_read_only(cls[3]),
    .cmd_bad_size(cls[2]), .cmd_overflow(cls[1]), .cmd_unknown(cls[0]),
    .rd_valid_reg, .rd_data_reg, .broadcast_req, .alarm_valid_reg, .alarm_broadcast_reg,
    .gauge_flag_word_reg(word), .charging, .charge_termination, .charge_tick,
    .capacity_mode, .remaining_charge_value(rem), .full_charge_value(full),
    .max_overcharge(maxo), .temperature(temp), .over_temp_charge(otc),
    .over_temp_charge_reset(otcr), .over_temp_discharge(otd),
    .over_temp_discharge_reset(otdr), .pack_voltage(vpk), .cell_voltage(vcl),
    .terminate_voltage(vtm), .suspend_temp_low(tlo), .cell_undervoltage_indication(cuv),
    .capacity_alarm_level(cap_l), .time_alarm_level(time_l), .discharge_current(i_d),
    .discharge_power(p_d), .average_time_to_empty_value(atte),
    .relative_charge_percent(rsoc), .full_clear_percent(fc_c),
    .battery_low_percent(low_p), .second_end_of_discharge_threshold(edv),
    .overload_current(i_ov), .config_valid_load(cfg_ok), .config_bad_load(cfg_bad));
  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_w
  task automatic chk_b(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_b
  task automatic bit_is(input int b, input logic e);
    chk_b(word[b], e);
  endtask : bit_is
  task automatic settle();
    repeat (3) @(negedge core_clk);
  endtask : settle
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
    @(negedge core_clk);
  endtask : pulse
  task automatic t_access();
    chk_w(word, `FLAG_WORD_RESET);
    host.issue(1'b0, `FLAG_WORD_CMD, 7'h00);
    chk_b(rd_valid_reg, 1'b1);
    chk_w(rd_data_reg, 16'h0040);
    @(negedge core_clk);
    chk_b(rd_valid_reg, 1'b0);
    host.issue(1'b1, `FLAG_WORD_CMD, 7'h08);
    settle();
    chk_w(word, 16'h0044);
    host.issue(1'b0, `FLAG_WORD_CMD, 7'h00);
    chk_w(rd_data_reg, 16'h0044);
    for (int i = 0; i < 11; i++) begin
      host.issue(ETAB[i][11], 8'h1d, ETAB[i][10:4]);
      settle();
      chk_w(word & 16'h000f, {12'h000, ETAB[i][3:0]});
    end
    $display("access test done");
  endtask : t_access
  task automatic t_init();
    pulse(cfg_ok);
    settle();
    chk_w(word, 16'h00c0);
    broadcast_req = 1'b1;
    @(negedge core_clk);
    broadcast_req = 1'b0;
    chk_b(alarm_valid_reg, 1'b1);
    chk_w(alarm_broadcast_reg, 16'h00cf);
    @(negedge core_clk);
    chk_b(alarm_valid_reg, 1'b0);
    pulse(cfg_bad);
    settle();
    bit_is(`BIT_INITIALIZED, 1'b0);
    $display("init test done");
  endtask : t_init
  task automatic t_charge();
    rsoc = 16'h005f;
    charging = 1'b1;
    rem = 16'h0900;
    settle();
    bit_is(`BIT_OVER_CHARGED_ALARM, 1'b1);
    bit_is(`BIT_FULLY_CHARGED, 1'b1);
    bit_is(`BIT_DISCHARGING, 1'b0);
    pulse(charge_termination);
    settle();
    bit_is(`BIT_TERM_CHARGE_ALARM, 1'b1);
    charging = 1'b0;
    rem = 16'h0400;
    pulse(charge_tick);
    pulse(charge_tick);
    settle();
    bit_is(`BIT_TERM_CHARGE_ALARM, 1'b0);
    bit_is(`BIT_DISCHARGING, 1'b1);
    bit_is(`BIT_OVER_CHARGED_ALARM, 1'b1);
    pulse(charge_tick);
    settle();
    bit_is(`BIT_OVER_CHARGED_ALARM, 1'b0);
    rsoc = 16'h0032;
    settle();
    bit_is(`BIT_FULLY_CHARGED, 1'b0);
    $display("charge test done");
  endtask : t_charge
  task automatic t_temp();
    charging = 1'b1;
    temp = 16'h0200;
    settle();
    bit_is(`BIT_OVER_TEMP_ALARM, 1'b1);
    temp = 16'h01c0;
    settle();
    bit_is(`BIT_OVER_TEMP_ALARM, 1'b1);
    temp = 16'h01bf;
    settle();
    bit_is(`BIT_OVER_TEMP_ALARM, 1'b0);
    charging = 1'b0;
    temp = 16'h0300;
    settle();
    bit_is(`BIT_OVER_TEMP_ALARM, 1'b1);
    temp = 16'h02bf;
    settle();
    bit_is(`BIT_OVER_TEMP_ALARM, 1'b0);
    temp = 16'h0100;
    $display("temperature test done");
  endtask : t_temp
  task automatic t_empty();
    rem = 16'h0000;
    settle();
    bit_is(`BIT_TERM_DISCHARGE_ALARM, 1'b1);
    bit_is(`BIT_CAPACITY_ALARM, 1'b1);
    rem = 16'h0400;
    settle();
    bit_is(`BIT_TERM_DISCHARGE_ALARM, 1'b0);
    bit_is(`BIT_CAPACITY_ALARM, 1'b0);
    vpk = 16'h2000;
    settle();
    bit_is(`BIT_TERM_DISCHARGE_ALARM, 1'b1);
    vpk = 16'h3000;
    tlo = 16'h0100;
    settle();
    bit_is(`BIT_TERM_DISCHARGE_ALARM, 1'b1);
    tlo = 16'h0000;
    cuv = 1'b1;
    settle();
    bit_is(`BIT_TERM_DISCHARGE_ALARM, 1'b1);
    cuv = 1'b0;
    settle();
    bit_is(`BIT_TERM_DISCHARGE_ALARM, 1'b0);
    vcl = 16'h0a00;
    settle();
    bit_is(`BIT_FULLY_DISCHARGED, 1'b1);
    vcl = 16'h0e00;
    rsoc = 16'h0013;
    settle();
    bit_is(`BIT_FULLY_DISCHARGED, 1'b1);
    rsoc = 16'h0014;
    settle();
    bit_is(`BIT_FULLY_DISCHARGED, 1'b0);
    $display("empty test done");
  endtask : t_empty
  task automatic t_time();
    i_d = 16'h0064;
    time_l = 16'h0300;
    settle();
    bit_is(`BIT_TIME_ALARM, 1'b1);
    time_l = 16'h000a;
    settle();
    bit_is(`BIT_TIME_ALARM, 1'b0);
    capacity_mode = 1'b1;
    time_l = 16'h0300;
    settle();
    bit_is(`BIT_TIME_ALARM, 1'b0);
    p_d = 16'h0064;
    settle();
    bit_is(`BIT_TIME_ALARM, 1'b1);
    $display("time test done");
  endtask : t_time
  task automatic test_done();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  initial begin
    {broadcast_req, charging, charge_termination, charge_tick} = 4'h0;
    {capacity_mode, cuv, cfg_ok, cfg_bad} = 4'h0;
    {rem, full, maxo, temp} = {16'h0400, 16'h0800, 16'h0080, 16'h0100};
    {otc, otcr, otd, otdr} = {16'h0200, 16'h01c0, 16'h0300, 16'h02c0};
    {vpk, vcl, vtm, tlo} = {16'h3000, 16'h0e00, 16'h2000, 16'h0000};
    {cap_l, time_l, i_d, p_d} = {16'h0040, 16'h000a, 16'h0000, 16'h0000};
    {atte, rsoc, fc_c, low_p} = {16'h0258, 16'h0032, 16'h005a, 16'h000a};
    {edv, i_ov} = {16'h0b00, 16'h1000};
    repeat (6) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (2) @(negedge core_clk);
    t_access();
    t_init();
    t_charge();
    t_temp();
    t_empty();
    t_time();
    test_done();
  end
  // The whole sequence needs well under 500 cycles.
  initial begin
    #100000;
    n_errors++;
    test_done();
  end
endmodule : gauge_flag_word_tb
